// file: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import rtc_pkg::*;
   // ***********************************
   // Signals and design
   // ***********************************
   localparam int unsigned MISS = 20;
   localparam int unsigned BLANK = 16;
   localparam logic [31:0] RUN = 32'h0000_0001 << RUN_BIT;
   localparam logic [31:0] AEN = 32'h0000_0001 << AEN_BIT;
   localparam logic [31:0] ARST = 32'h0000_0001 << ALARM_FLAG_AUTORESET_BIT_BIT;
   localparam logic [31:0] SETR = 32'h0000_0001 << SET_BIT;
   localparam logic [31:0] CAPR = 32'h0000_0001 << CAP_BIT;
   localparam logic [31:0] MCK = 32'h0000_0001 << MCLK_EN_BIT;
   localparam logic [31:0] FAILB = 32'h0000_0001 << FAIL_BIT;
   localparam logic [31:0] OSCE = 32'h0000_0001 << OSC_EN_BIT;
   localparam logic [31:0] VAL = 32'h0000_0001 << VALID_BIT;
   typedef struct {logic [31:0] data; logic [31:0] mask;} rtc_note_type;
   logic pclk, presetn, clk_en, psel, penable, pwrite, osc_pin, amp_detect_pin;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, v;
   logic pready, pslverr, osc_enable, alarm_event, osc_fail_event, err;
   logic alarm_q = 1'b0;
   rtc_note_type notes[$];
   rtc_note_type nt;
   int failures = 0;
   int num_checks = 0;
   int alarm_cnt = 0;
   int hi_run = 0;
   int hi_max = 0;
   int n, a0;

   rtc_top #(.MISS_CYCLES(MISS), .BLANK_CYCLES(BLANK)) u_rtc_top (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .osc_pin(osc_pin), .amp_detect_pin(amp_detect_pin),
      .osc_enable(osc_enable), .alarm_event(alarm_event), .osc_fail_event(osc_fail_event));

   // 100 MHz system clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ***********************************
   // Checking and verdict
   // ***********************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   // Read data compared against the oldest note at the sampling edge
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (notes.size() == 0) begin
            failures++;
         end else begin
            nt = notes.pop_front();
            check(prdata & nt.mask, nt.data);
         end
      end
   end

   // Alarm pulse count and longest high run, for width checks
   always @(posedge pclk) begin
      alarm_q <= alarm_event;
      if (alarm_event && !alarm_q) alarm_cnt <= alarm_cnt + 1;
      hi_run <= alarm_event ? hi_run + 1 : 0;
      if (hi_run > hi_max) hi_max <= hi_run;
   end

   // ***********************************
   // Bus and pin drivers
   // ***********************************
   // Request held until pready is seen; psel drops for a cycle between calls
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         failures++;
         print_verdict();
      end
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      notes.push_back('{e & m, m});
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd

   // Oscillator period of 16 pclk; tail lets the synchroniser settle
   task automatic osc_cycles(input int c);
      repeat (c) begin
         @(posedge pclk);
         osc_pin <= 1'b1;
         repeat (8) @(posedge pclk);
         osc_pin <= 1'b0;
         repeat (7) @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
   endtask : osc_cycles

   task automatic wait_hi(ref logic s, output int cyc);
      cyc = 0;
      while (s !== 1'b1) begin
         @(posedge pclk);
         cyc++;
         if (cyc > 500) begin
            failures++;
            print_verdict();
         end
      end
   endtask : wait_hi

   // Counter loaded to zero with a match value of 3, then run with the given control
   task automatic alarm_run(input logic [31:0] ctl, input int ticks);
      wr(MATCH_OFS, 32'h0000_0003);
      wr(CAPT_OFS, 32'h0000_0000);
      wr(CTRL_OFS, SETR);
      a0 = alarm_cnt;
      wr(CTRL_OFS, ctl);
      osc_cycles(ticks);
      wr(CTRL_OFS, CAPR);
   endtask : alarm_run

   // ***********************************
   // Scenarios
   // ***********************************
   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      osc_pin = 1'b0;
      amp_detect_pin = 1'b0;
      v = $urandom(32'h752f0c00);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and an unmapped address
      rd(CTRL_OFS, WORD_RST, WORD_MAX);
      rd(OSCCTL_OFS, WORD_RST, WORD_MAX);
      rd(CAPT_OFS, WORD_RST, WORD_MAX);
      rd(MATCH_OFS, WORD_RST, WORD_MAX);
      rd(8'h10, 32'h0000_0000, WORD_MAX);
      check(32'(err), 32'h0000_0001);
      // Random load and snapshot with the counter held
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         wr(MATCH_OFS, ~v);
         rd(MATCH_OFS, ~v, WORD_MAX);
         wr(CAPT_OFS, v);
         wr(CTRL_OFS, SETR);
         rd(CTRL_OFS, 32'h0000_0000, SETR);
         wr(CAPT_OFS, 32'h0000_0000);
         osc_cycles(2);
         wr(CTRL_OFS, CAPR);
         rd(CTRL_OFS, 32'h0000_0000, CAPR);
         rd(CAPT_OFS, v, WORD_MAX);
      end
      // Wrap through the maximum, captured while running
      wr(CAPT_OFS, 32'hFFFF_FFFE);
      wr(CTRL_OFS, SETR);
      // Match two ahead by a wrapping add lands on zero
      a0 = alarm_cnt;
      wr(MATCH_OFS, 32'hFFFF_FFFE + 32'h0000_0002);
      wr(CTRL_OFS, RUN | AEN);
      osc_cycles(3);
      wr(CTRL_OFS, RUN | CAPR);
      rd(CAPT_OFS, 32'h0000_0001, WORD_MAX);
      check(32'(alarm_cnt - a0), 32'h0000_0001);
      // Frozen clock enable holds the counter through oscillator ticks
      clk_en <= 1'b0;
      osc_cycles(2);
      clk_en <= 1'b1;
      wr(CTRL_OFS, CAPR);
      rd(CAPT_OFS, 32'h0000_0001, WORD_MAX);
      // Auto-reset gives a period of match plus two
      alarm_run(RUN | AEN | ARST, 10);
      rd(CAPT_OFS, 32'h0000_0000, WORD_MAX);
      check(32'(alarm_cnt - a0), 32'h0000_0002);
      alarm_run(RUN | AEN, 10);
      rd(CAPT_OFS, 32'h0000_000A, WORD_MAX);
      check(32'(alarm_cnt - a0), 32'h0000_0001);
      check(32'(hi_max <= 16), 32'h0000_0001);
      // Alarm flag cleared by disabling alarms; match two ticks ahead
      wr(MATCH_OFS, 32'h0000_000C);
      wr(CTRL_OFS, RUN | AEN);
      fork
         osc_cycles(4);
         begin
            wait_hi(alarm_event, n);
            wr(CTRL_OFS, RUN);
            repeat (2) @(posedge pclk);
            check(32'(alarm_event), 32'h0000_0000);
         end
      join
      rd(CTRL_OFS, 32'h0000_0000, ARST);
      // Missing clock: stalled oscillator, then a running one
      wr(CTRL_OFS, MCK);
      wait_hi(osc_fail_event, n);
      check(32'(n >= MISS - 2 && n <= MISS + 6), 32'h0000_0001);
      rd(CTRL_OFS, FAILB, FAILB);
      wr(CTRL_OFS, 32'h0000_0000);
      rd(CTRL_OFS, 32'h0000_0000, FAILB);
      check(32'(osc_fail_event), 32'h0000_0000);
      wr(CTRL_OFS, MCK);
      osc_cycles(4);
      wr(CTRL_OFS, 32'h0000_0000);
      check(32'(osc_fail_event), 32'h0000_0000);
      // Crystal valid masked during blanking
      amp_detect_pin <= 1'b1;
      wr(CTRL_OFS, OSCE);
      rd(OSCCTL_OFS, 32'h0000_0000, VAL);
      repeat (BLANK + 8) @(posedge pclk);
      rd(OSCCTL_OFS, VAL, VAL);
      check(32'(osc_enable), 32'h0000_0001);
      amp_detect_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(OSCCTL_OFS, 32'h0000_0000, VAL);
      repeat (4) @(posedge pclk);
      print_verdict();
   end
endmodule : tb_top

// file: hdl/rtc_pkg.sv
package rtc_pkg;
   // ***********************************
   // Timing
   // ***********************************
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned MISS_TIME_US = 100;
   localparam int unsigned MISS_CYCLES = MISS_TIME_US * CLK_MHZ;
   localparam int unsigned BLANK_TIME_MS = 2;
   localparam int unsigned BLANK_CYCLES = BLANK_TIME_MS * 1000 * CLK_MHZ;

   // ***********************************
   // Register map (byte addresses)
   // ***********************************
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] OSCCTL_OFS = 8'h04;
   localparam logic [7:0] CAPT_OFS = 8'h08;
   localparam logic [7:0] MATCH_OFS = 8'h0C;

   // ***********************************
   // Control register fields
   // ***********************************
   localparam int unsigned OSC_EN_BIT = 7;
   localparam int unsigned MCLK_EN_BIT = 6;
   localparam int unsigned FAIL_BIT = 5;
   localparam int unsigned RUN_BIT = 4;
   localparam int unsigned AEN_BIT = 3;
   localparam int unsigned ALARM_FLAG_AUTORESET_BIT_BIT = 2;
   localparam int unsigned SET_BIT = 1;
   localparam int unsigned CAP_BIT = 0;
   localparam int unsigned VALID_BIT = 4;

   // ***********************************
   // Reset values and the all-ones word
   // ***********************************
   localparam logic CTRL_BIT_RST = 1'b0;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [31:0] WORD_MAX = 32'hFFFF_FFFF;
endpackage : rtc_pkg

// file: hdl/rtc_sync3.sv
`timescale 1ns/1ns
module rtc_sync3 (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Pin and filtered level
   input wire logic pin_in,
   output logic level_out
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;

   // Three stages; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else if (clk_en) begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Level moves only when the last two stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_out <= 1'b0;
      end else if (clk_en && (s2_ff == s3_ff)) begin
         level_out <= s3_ff;
      end
   end
endmodule : rtc_sync3

// file: hdl/rtc_timeout.sv
`timescale 1ns/1ns
module rtc_timeout #(
   parameter int unsigned CYCLES = 100
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Control and result
   input wire logic restart,
   output logic done,
   output logic done_pulse
);
   localparam int unsigned WIDTH = $clog2(CYCLES + 1);
   localparam logic [WIDTH-1:0] LAST = WIDTH'(CYCLES);

   logic [WIDTH-1:0] count_ff;

   // Saturating count; stops at the limit so the result fires once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= '0;
      end else if (clk_en) begin
         if (restart) begin
            count_ff <= '0;
         end else if (count_ff != LAST) begin
            count_ff <= count_ff + 1'b1;
         end
      end
   end

   assign done = (count_ff == LAST);
   assign done_pulse = clk_en && !restart && (count_ff == LAST - 1'b1);
endmodule : rtc_timeout

// file: hdl/rtc_top.sv
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module rtc_top #(
   parameter int unsigned MISS_CYCLES = rtc_pkg::MISS_CYCLES,
   parameter int unsigned BLANK_CYCLES = rtc_pkg::BLANK_CYCLES
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rtc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Oscillator pins
   input wire logic osc_pin,
   input wire logic amp_detect_pin,
   output logic osc_enable,
   // System events
   output logic alarm_event,
   output logic osc_fail_event
);
   import rtc_pkg::*;

   // ***********************************
   // Declarations
   // ***********************************
   logic osc_en_ff;
   logic mclk_en_ff;
   logic fail_ff;
   logic run_ff;
   logic aen_ff;
   logic autoreset_ff;
   logic set_req_ff;
   logic cap_req_ff;
   logic alarm_ff;
   logic ar_pend_ff;
   logic osc_lvl_ff;
   logic [31:0] count_ff;
   logic [31:0] capture_ff;
   logic [31:0] match_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_count;
   logic osc_lvl;
   logic amp_lvl;
   logic osc_tick;
   logic osc_edge;
   logic miss_pulse;
   logic blank_done;
   logic crystal_valid_status;
   logic wr_acc;
   logic wr_ctrl;
   logic mapped;
   logic step;

   // ***********************************
   // Pin synchronisers and timers
   // ***********************************
   rtc_sync3 u_osc_sync (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .pin_in(osc_pin),
      .level_out(osc_lvl)
   );

   rtc_sync3 u_amp_sync (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .pin_in(amp_detect_pin),
      .level_out(amp_lvl)
   );

   // Missing clock watchdog, restarted by any oscillator edge
   rtc_timeout #(.CYCLES(MISS_CYCLES)) u_miss (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .restart(!mclk_en_ff || osc_edge),
      .done(),
      .done_pulse(miss_pulse)
   );

   // Blanking after the oscillator is switched on
   rtc_timeout #(.CYCLES(BLANK_CYCLES)) u_blank (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .restart(!osc_en_ff),
      .done(blank_done),
      .done_pulse()
   );

   // Delayed filtered level for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_lvl_ff <= 1'b0;
      end else if (clk_en) begin
         osc_lvl_ff <= osc_lvl;
      end
   end

   assign osc_edge = (osc_lvl != osc_lvl_ff);
   assign osc_tick = osc_lvl && !osc_lvl_ff;  // Rising edge = one oscillator cycle
   // Detector output is not trusted until blanking ends
   assign crystal_valid_status = osc_en_ff && blank_done && amp_lvl;
   assign osc_enable = osc_en_ff;

   // ***********************************
   // APB slave
   // ***********************************
   // Zero wait states; a frozen clock enable stalls the bus instead
   assign pready = clk_en;
   assign mapped = (paddr == CTRL_OFS) || (paddr == OSCCTL_OFS) ||
                   (paddr == CAPT_OFS) || (paddr == MATCH_OFS);
   assign pslverr = psel && penable && !mapped;
   assign wr_acc = psel && penable && pwrite && clk_en && mapped;
   assign wr_ctrl = wr_acc && (paddr == CTRL_OFS);
   assign prdata = rdata_ff;

   // Read data latched in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= WORD_RST;
      end else if (clk_en && psel && !penable && !pwrite) begin
         case (paddr)
            CTRL_OFS: begin
               rdata_ff <= {24'h00_0000, osc_en_ff, mclk_en_ff, fail_ff, run_ff,
                            aen_ff, alarm_ff, set_req_ff, cap_req_ff};
            end
            OSCCTL_OFS: begin
               rdata_ff <= 32'(crystal_valid_status) << VALID_BIT;
            end
            CAPT_OFS: begin
               rdata_ff <= capture_ff;
            end
            MATCH_OFS: begin
               rdata_ff <= match_ff;
            end
            default: begin
               rdata_ff <= WORD_RST;
            end
         endcase
      end
   end

   // ***********************************
   // Control bits
   // ***********************************
   // Plain software controls; alarm bit position holds auto-reset enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_en_ff <= CTRL_BIT_RST;
         mclk_en_ff <= CTRL_BIT_RST;
         run_ff <= CTRL_BIT_RST;
         aen_ff <= CTRL_BIT_RST;
         autoreset_ff <= CTRL_BIT_RST;
      end else if (wr_ctrl) begin
         osc_en_ff <= pwdata[OSC_EN_BIT];
         mclk_en_ff <= pwdata[MCLK_EN_BIT];
         run_ff <= pwdata[RUN_BIT];
         aen_ff <= pwdata[AEN_BIT];
         autoreset_ff <= pwdata[ALARM_FLAG_AUTORESET_BIT_BIT];
      end
   end

   // Failure flag: one-shot set by the watchdog, set beats a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_ff <= CTRL_BIT_RST;
      end else if (clk_en) begin
         if (mclk_en_ff && miss_pulse) begin
            fail_ff <= 1'b1;
         end else if (wr_ctrl) begin
            fail_ff <= pwdata[FAIL_BIT];
         end
      end
   end

   assign osc_fail_event = fail_ff;

   // Requests drop in the same edge that completes the copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         set_req_ff <= CTRL_BIT_RST;
         cap_req_ff <= CTRL_BIT_RST;
      end else if (clk_en) begin
         if (wr_ctrl && pwdata[SET_BIT]) begin
            set_req_ff <= 1'b1;
         end else if (set_req_ff) begin
            set_req_ff <= 1'b0;
         end
         if (wr_ctrl && pwdata[CAP_BIT]) begin
            cap_req_ff <= 1'b1;
         end else if (cap_req_ff) begin
            cap_req_ff <= 1'b0;
         end
      end
   end

   // ***********************************
   // Holding and match registers
   // ***********************************
   // Snapshot wins over a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_ff <= WORD_RST;
      end else if (clk_en) begin
         if (cap_req_ff) begin
            capture_ff <= count_ff;
         end else if (wr_acc && (paddr == CAPT_OFS)) begin
            capture_ff <= pwdata;
         end
      end
   end

   // Match value; software keeps the alarm disabled while changing it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_ff <= WORD_RST;
      end else if (wr_acc && (paddr == MATCH_OFS)) begin
         match_ff <= pwdata;
      end
   end

   // ***********************************
   // Counter
   // ***********************************
   assign step = clk_en && osc_tick && run_ff;
   // Natural 32-bit wrap; auto-reset replaces the step after an alarm
   assign nxt_count = ar_pend_ff ? WORD_RST : count_ff + 32'h0000_0001;

   // Load request has priority; counting never needs a stop first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= WORD_RST;
      end else if (clk_en) begin
         if (set_req_ff) begin
            count_ff <= capture_ff;
         end else if (step) begin
            count_ff <= nxt_count;
         end
      end
   end

   // ***********************************
   // Alarm
   // ***********************************
   // Raised only on a step that lands on the match value, so an
   // unchanged match after re-enable waits a full wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_ff <= CTRL_BIT_RST;
      end else if (clk_en) begin
         if (wr_ctrl && !pwdata[AEN_BIT]) begin
            alarm_ff <= 1'b0;
         end else if (step && !set_req_ff) begin
            alarm_ff <= aen_ff && (nxt_count == match_ff);
         end
      end
   end

   assign alarm_event = alarm_ff;

   // Auto-reset armed as the alarm drops, used on the next step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ar_pend_ff <= CTRL_BIT_RST;
      end else if (clk_en) begin
         if (!autoreset_ff || set_req_ff) begin
            ar_pend_ff <= 1'b0;
         end else if (step) begin
            ar_pend_ff <= alarm_ff;
         end
      end
   end

   // ***********************************
   // Assertions
   // ***********************************
   miss_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mclk_en_ff && miss_pulse) |=> fail_ff && osc_fail_event)
      else $error("watchdog expiry did not set failure flag");

   fail_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!mclk_en_ff && !fail_ff && !wr_ctrl) |=> !fail_ff)
      else $error("failure flag set with monitor off");

   fail_event_a: assert property (@(posedge pclk) disable iff (!presetn)
      (fail_ff && !wr_ctrl) |=> fail_ff && osc_fail_event)
      else $error("failure event dropped without software");

   blank_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(osc_en_ff) |-> !crystal_valid_status [*8])
      else $error("crystal valid inside blanking");

   count_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
      (step && !set_req_ff && !ar_pend_ff) |=> count_ff == $past(count_ff) + 32'h0000_0001)
      else $error("counter did not step by one");

   count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!run_ff && !set_req_ff) |=> $stable(count_ff))
      else $error("stopped counter moved");

   wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      (step && !set_req_ff && count_ff == WORD_MAX) |=> count_ff == WORD_RST)
      else $error("counter did not wrap to zero");

   alarm_eq_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(alarm_ff) |-> (count_ff == match_ff) && $past(aen_ff))
      else $error("alarm without match");

   // Arming as the flag drops, then the clear on the next step
   auto_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
      (step && alarm_ff && autoreset_ff && !set_req_ff) |=> ar_pend_ff)
      else $error("auto-reset not armed as alarm dropped");

   auto_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      (step && ar_pend_ff && !set_req_ff) |=> count_ff == WORD_RST)
      else $error("auto-reset did not clear counter");

   set_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      (set_req_ff && clk_en) |=> (count_ff == $past(capture_ff)) && !set_req_ff)
      else $error("set request did not load counter");

   cap_snap_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cap_req_ff && clk_en) |=> (capture_ff == $past(count_ff)) && !cap_req_ff)
      else $error("capture request did not snapshot");

   aen_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ctrl && !pwdata[AEN_BIT]) |=> !alarm_ff)
      else $error("disabling alarm left flag set");

   alarm_short_a: assert property (@(posedge pclk) disable iff (!presetn)
      (alarm_ff && step && !set_req_ff) |=> !alarm_ff)
      else $error("alarm flag outlived one oscillator cycle");
endmodule : rtc_top
